// ===== tcp_map.svh
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

// ----------------------------------------------------------------------
// Reset and reload values
// ----------------------------------------------------------------------
`define TCP_CMP_RESET     8'h00
`define TCP_CNT_RELOAD    8'hFC
`define TCP_CNT_WRAP      8'h00
`define TCP_CAP1_PULSE    16'hFFFD
`define TCP_CMP_STEP      8'h01

// ----------------------------------------------------------------------
// Prescaler selection codes and division ratios
// ----------------------------------------------------------------------
`define TCP_SEL_DIV2      2'h0
`define TCP_SEL_DIV4      2'h1
`define TCP_SEL_DIV8      2'h2
`define TCP_SEL_SLOW      2'h3
`define TCP_DIV2          14'h0002
`define TCP_DIV4          14'h0004
`define TCP_DIV8          14'h0008
`define TCP_DIV_SLOW      14'h1F40
`define TCP_PRE_ZERO      14'h0000
`define TCP_PRE_ONE       14'h0001

`endif

// ===== tcp_pkg.sv
package tcp_pkg;

   typedef logic [7:0] tcp_byte_type;

   typedef enum logic [1:0] {
      TCP_MODE_NORMAL,
      TCP_MODE_PULSE,
      TCP_MODE_PWM
   } tcp_mode_type;

endpackage : tcp_pkg

// ===== tcp_tick_if.sv
`timescale 1ns/10ps
interface tcp_tick_if;
   logic [1:0] sel;
   logic       tick;

   modport src (input sel, output tick);
   modport dst (output sel, input tick);
endinterface : tcp_tick_if

// ===== tcp_prescaler.sv
`timescale 1ns/10ps
`include "tcp_map.svh"

// ----------------------------------------------------------------------
// Timer clock enable divider
// ----------------------------------------------------------------------
module tcp_prescaler #(
   parameter logic [13:0] DIV_SLOW = `TCP_DIV_SLOW
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst_b,
   tcp_tick_if.src   tick_if
);

   generate
      if (DIV_SLOW < `TCP_DIV2) begin : g_bad_div
         $error("Slow division ratio must be at least two.");
      end
   endgenerate

   logic [13:0] cnt_q;
   logic [13:0] cnt_d;
   logic        tick_q;
   logic        tick_d;
   logic [13:0] div_last;

   always_comb begin
      case (tick_if.sel)
         `TCP_SEL_DIV2: div_last = `TCP_DIV2 - `TCP_PRE_ONE;
         `TCP_SEL_DIV4: div_last = `TCP_DIV4 - `TCP_PRE_ONE;
         `TCP_SEL_DIV8: div_last = `TCP_DIV8 - `TCP_PRE_ONE;
         default:       div_last = DIV_SLOW - `TCP_PRE_ONE;
      endcase
      // A selection change past the current count restarts the period.
      if (cnt_q >= div_last) begin
         cnt_d  = `TCP_PRE_ZERO;
         tick_d = 1'b1;
      end else begin
         cnt_d  = cnt_q + `TCP_PRE_ONE;
         tick_d = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         cnt_q  <= `TCP_PRE_ZERO;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_if.tick = tick_q;

endmodule : tcp_prescaler

// ===== tcp_compare.sv
`timescale 1ns/10ps
`include "tcp_map.svh"

// What this block does
// (R1) Reset clears both compare values to zero.
// (R2) Compare values software owned, hardware never modifies.
// (R3) Match sets flag, drives level, raises interrupt.
// (R4) Output pin latches held low in reset.
// (R5) Flag clears after status read then access.
// (R6) Disabled pin ignores match; interrupt still possible.
// (R7) Divide-by-two matches equal, others equal plus one.
// (R8) Prescaler divides by 2, 4, 8, 8000.
// (R9) Force copies level, no flag, no interrupt.
// (R10) Force ignored in pulse or PWM mode.
// (R11) Pulse trigger reloads counter, starts pulse, captures.
// (R12) Compare 1 match in pulse mode ends pulse.
// (R13) Pulse mode: flag 1 never, flag 2 works.
// (R14) PWM wins when both modes selected.
// (R15) Modes disable capture 1; capture 2 remains.
// (R16) Pulse mode: channel 2 gives no waveform.
// (R17) PWM compare values double buffered per period.
// (R18) PWM compare 2 match reloads counter.
// (R19) PWM pin takes level 1, then level 2.
// (R20) PWM mode never sets compare flags.
// (R21) PWM compare 2 match sets capture flag 1.
// (R22) Software handler checks and clears both flags.
// (R23) Counter counts up; rollover sets overflow flag.
module tcp_compare #(
   parameter logic [13:0] DIV_SLOW = `TCP_DIV_SLOW
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_b,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_cmp1_wr,
   input  wire logic       i_cmp2_wr,
   input  wire logic       i_cmp1_rd,
   input  wire logic       i_cmp2_rd,
   input  wire logic       i_cap1_rd,
   input  wire logic       i_cap2_rd,
   input  wire logic       i_cnt_rd,
   input  wire logic       i_cnt_wr,
   input  wire logic       i_status_rd,
   input  wire logic       i_capture_irq_enable,
   input  wire logic       i_compare_irq_enable,
   input  wire logic       i_overflow_irq_enable,
   input  wire logic       i_force_level_bit_1,
   input  wire logic       i_force_level_bit_2,
   input  wire logic       i_level_bit_first,
   input  wire logic       i_level_bit_second,
   input  wire logic       i_capture1_edge_select,
   input  wire logic       i_capture2_edge_select,
   input  wire logic       i_compare_pin1_enable,
   input  wire logic       i_compare_pin2_enable,
   input  wire logic       i_single_pulse_select,
   input  wire logic       i_pwm_select,
   input  wire logic [1:0] i_prescale_select,
   input  wire logic       i_cpu_irq_mask,
   input  wire logic       i_capture_in_pin1,
   input  wire logic       i_capture_in_pin2,
   output logic            o_compare_out_pin1,
   output logic            o_compare_out_pin1_oe,
   output logic            o_compare_out_pin2,
   output logic            o_compare_out_pin2_oe,
   output logic [7:0]      o_compare_value_1,
   output logic [7:0]      o_compare_value_2,
   output logic [7:0]      o_capture_value_1,
   output logic [7:0]      o_capture_value_2,
   output logic [7:0]      o_counter,
   output logic            o_match_flag_1,
   output logic            o_match_flag_2,
   output logic            o_capture_flag_1,
   output logic            o_capture_flag_2,
   output logic            o_overflow_flag,
   output logic            o_timer_irq
);

   // -------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------
   function automatic logic cmp_hit(input tcp_pkg::tcp_byte_type cnt,
                                    input tcp_pkg::tcp_byte_type val,
                                    input logic                  fast);
      tcp_pkg::tcp_byte_type tgt;
      tgt = fast ? val : val + `TCP_CMP_STEP;
      return cnt == tgt;
   endfunction : cmp_hit

   // Returns {arm, flag}; a set in the clearing cycle wins.
   function automatic logic [1:0] flag_next(input logic set,
                                            input logic flag,
                                            input logic arm,
                                            input logic status_rd,
                                            input logic access);
      logic clr;
      logic arm_n;
      clr   = arm & access;
      arm_n = (status_rd & flag) | (arm & ~access);
      return {arm_n & ~set, set | (flag & ~clr)};
   endfunction : flag_next

   // -------------------------------------------------------------------
   // Prescaler and input synchronisers
   // -------------------------------------------------------------------
   tcp_tick_if tick_if ();
   assign tick_if.sel = i_prescale_select;

   tcp_prescaler #(
      .DIV_SLOW (DIV_SLOW)
   ) u_pre (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .tick_if    (tick_if.src)
   ); // R8

   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] prev_q;
   logic       tick_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         prev_q  <= 2'h0;
         tick_q  <= 1'b0;
      end else begin
         sync1_q <= {i_capture_in_pin2, i_capture_in_pin1};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
         tick_q  <= tick_if.tick;
      end
   end

   // -------------------------------------------------------------------
   // Mode and event decode
   // -------------------------------------------------------------------
   tcp_pkg::tcp_mode_type mode;
   logic                  fast;
   logic                  edge1;
   logic                  edge2;
   logic                  hit1;
   logic                  hit2;

   tcp_pkg::tcp_byte_type cmp1_q;
   tcp_pkg::tcp_byte_type cmp2_q;
   tcp_pkg::tcp_byte_type act1_q;
   tcp_pkg::tcp_byte_type act2_q;
   tcp_pkg::tcp_byte_type cnt_q;
   tcp_pkg::tcp_byte_type cap1_q;
   tcp_pkg::tcp_byte_type cap2_q;

   always_comb begin
      if (i_pwm_select) begin
         mode = tcp_pkg::TCP_MODE_PWM; // R14
      end else if (i_single_pulse_select) begin
         mode = tcp_pkg::TCP_MODE_PULSE;
      end else begin
         mode = tcp_pkg::TCP_MODE_NORMAL;
      end
      fast  = i_prescale_select == `TCP_SEL_DIV2;
      edge1 = (sync2_q[0] ^ prev_q[0])
            & (sync2_q[0] == i_capture1_edge_select);
      edge2 = (sync2_q[1] ^ prev_q[1])
            & (sync2_q[1] == i_capture2_edge_select);
      // One pulse per counter value, on the cycle after it changes.
      hit1 = tick_q & cmp_hit(cnt_q, (mode == tcp_pkg::TCP_MODE_PWM)
                                     ? act1_q : cmp1_q, fast); // R7
      hit2 = tick_q & cmp_hit(cnt_q, (mode == tcp_pkg::TCP_MODE_PWM)
                                     ? act2_q : cmp2_q, fast); // R7
   end

   // -------------------------------------------------------------------
   // Timer state
   // -------------------------------------------------------------------
   logic                  pin1_q;
   logic                  pin2_q;
   logic                  oe1_q;
   logic                  oe2_q;
   logic                  irq_q;
   logic [4:0]            flag_q;
   logic [4:0]            arm_q;
   tcp_pkg::tcp_byte_type cmp1_d;
   tcp_pkg::tcp_byte_type cmp2_d;
   tcp_pkg::tcp_byte_type act1_d;
   tcp_pkg::tcp_byte_type act2_d;
   tcp_pkg::tcp_byte_type cnt_d;
   tcp_pkg::tcp_byte_type cap1_d;
   tcp_pkg::tcp_byte_type cap2_d;
   logic                  pin1_d;
   logic                  pin2_d;
   logic                  irq_d;
   logic [4:0]            flag_d;
   logic [4:0]            arm_d;
   logic [4:0]            set;
   logic [4:0]            access;
   logic [1:0]            fa;

   always_comb begin
      // Only software writes reach the compare values.
      cmp1_d = i_cmp1_wr ? i_wdata : cmp1_q; // R2
      cmp2_d = i_cmp2_wr ? i_wdata : cmp2_q; // R2
      // Outside PWM the buffers track the software values directly.
      act1_d = (mode == tcp_pkg::TCP_MODE_PWM) ? act1_q : cmp1_q;
      act2_d = (mode == tcp_pkg::TCP_MODE_PWM) ? act2_q : cmp2_q;
      cnt_d  = cnt_q;
      cap1_d = cap1_q;
      cap2_d = edge2 ? cnt_q : cap2_q; // R15
      pin1_d = pin1_q;
      pin2_d = pin2_q;
      set    = 5'h00;
      fa     = 2'h0;
      set[4] = tick_q && cnt_q == `TCP_CNT_WRAP; // R23
      set[3] = edge2; // R15
      if (tick_if.tick) begin
         cnt_d = cnt_q + `TCP_CMP_STEP; // R23
      end

      case (mode)
         tcp_pkg::TCP_MODE_PWM: begin
            if (hit1 && i_compare_pin1_enable) begin
               pin1_d = i_level_bit_first; // R19
            end
            if (hit2) begin
               cnt_d  = `TCP_CNT_RELOAD; // R18
               act1_d = cmp1_q; // R17
               act2_d = cmp2_q; // R17
               set[2] = 1'b1; // R21
               if (i_compare_pin1_enable) begin
                  pin1_d = i_level_bit_second; // R19
               end
            end
            // Neither match flag is set here. R20
         end
         tcp_pkg::TCP_MODE_PULSE: begin
            if (hit1 && i_compare_pin1_enable) begin
               pin1_d = i_level_bit_first; // R12
            end
            if (edge1) begin
               cnt_d  = `TCP_CNT_RELOAD; // R11
               cap1_d = 8'(`TCP_CAP1_PULSE); // R11
               set[2] = 1'b1; // R11
               if (i_compare_pin1_enable) begin
                  pin1_d = i_level_bit_second; // R11
               end
            end
            set[1] = hit2; // R13 R16
         end
         default: begin
            if (edge1) begin
               cap1_d = cnt_q;
               set[2] = 1'b1;
            end
            set[0] = hit1; // R3
            set[1] = hit2; // R3
            if (i_compare_pin1_enable
                && (hit1 || i_force_level_bit_1)) begin
               pin1_d = i_level_bit_first; // R3 R6 R9 R10
            end
            if (i_compare_pin2_enable
                && (hit2 || i_force_level_bit_2)) begin
               pin2_d = i_level_bit_second; // R3 R6 R9 R10
            end
         end
      endcase
      // A counter write wins over every other reload.
      cnt_d = i_cnt_wr ? `TCP_CNT_RELOAD : cnt_d;

      access = {i_cnt_rd | i_cnt_wr, i_cap2_rd, i_cap1_rd,
                i_cmp2_rd | i_cmp2_wr, i_cmp1_rd | i_cmp1_wr};
      for (int k = 0; k < 5; k++) begin
         fa = flag_next(set[k], flag_q[k], arm_q[k], i_status_rd,
                        access[k]); // R5
         arm_d[k]  = fa[1];
         flag_d[k] = fa[0];
      end

      irq_d = ~i_cpu_irq_mask
            & ((i_compare_irq_enable & (flag_q[0] | flag_q[1]))
             | (i_capture_irq_enable & (flag_q[2] | flag_q[3]))
             | (i_overflow_irq_enable & flag_q[4])); // R3 R21 R22
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         cmp1_q <= `TCP_CMP_RESET; // R1
         cmp2_q <= `TCP_CMP_RESET; // R1
         act1_q <= `TCP_CMP_RESET;
         act2_q <= `TCP_CMP_RESET;
         cnt_q  <= `TCP_CNT_RELOAD;
         cap1_q <= `TCP_CMP_RESET;
         cap2_q <= `TCP_CMP_RESET;
         pin1_q <= 1'b0; // R4
         pin2_q <= 1'b0; // R4
         oe1_q  <= 1'b0;
         oe2_q  <= 1'b0;
         irq_q  <= 1'b0;
         flag_q <= 5'h00;
         arm_q  <= 5'h00;
      end else begin
         cmp1_q <= cmp1_d;
         cmp2_q <= cmp2_d;
         act1_q <= act1_d;
         act2_q <= act2_d;
         cnt_q  <= cnt_d;
         cap1_q <= cap1_d;
         cap2_q <= cap2_d;
         pin1_q <= pin1_d;
         pin2_q <= pin2_d;
         oe1_q  <= i_compare_pin1_enable; // R6
         oe2_q  <= i_compare_pin2_enable; // R6
         irq_q  <= irq_d;
         flag_q <= flag_d;
         arm_q  <= arm_d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign o_compare_out_pin1    = pin1_q;
   assign o_compare_out_pin1_oe = oe1_q;
   assign o_compare_out_pin2    = pin2_q;
   assign o_compare_out_pin2_oe = oe2_q;
   assign o_compare_value_1     = cmp1_q;
   assign o_compare_value_2     = cmp2_q;
   assign o_capture_value_1     = cap1_q;
   assign o_capture_value_2     = cap2_q;
   assign o_counter             = cnt_q;
   assign o_match_flag_1        = flag_q[0];
   assign o_match_flag_2        = flag_q[1];
   assign o_capture_flag_1      = flag_q[2];
   assign o_capture_flag_2      = flag_q[3];
   assign o_overflow_flag       = flag_q[4];
   assign o_timer_irq           = irq_q;

endmodule : tcp_compare

// ===== tcp_ext_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Far side: sources on the two capture pins
// ----------------------------------------------------------------------
module tcp_ext_model (
   input  wire logic i_core_clk,
   output logic      o_cap1,
   output logic      o_cap2
);
   initial begin
      o_cap1 = 1'h0;
      o_cap2 = 1'h0;
   end

   // The level before the edge is held long enough for the synchroniser.
   task edge_on(input bit two, input bit rise);
      @(posedge i_core_clk);
      if (two) o_cap2 <= !rise;
      else o_cap1 <= !rise;
      repeat (4) @(posedge i_core_clk);
      if (two) o_cap2 <= rise;
      else o_cap1 <= rise;
   endtask : edge_on
endmodule : tcp_ext_model

// ===== tcp_compare_props.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------------
module tcp_compare_props #(
   parameter logic [13:0] DIV_SLOW = 14'h1F40
) (
   input wire logic       i_core_clk,
   input wire logic       i_rst_b,
   input wire logic [7:0] i_wdata,
   input wire logic       i_cmp1_wr,
   input wire logic       i_cmp2_wr,
   input wire logic       i_compare_irq_enable,
   input wire logic       i_force_level_bit_1,
   input wire logic       i_level_bit_first,
   input wire logic       i_compare_pin1_enable,
   input wire logic       i_single_pulse_select,
   input wire logic       i_pwm_select,
   input wire logic [1:0] i_prescale_select,
   input wire logic       i_cpu_irq_mask,
   input wire logic       o_compare_out_pin1,
   input wire logic       o_compare_out_pin1_oe,
   input wire logic       o_compare_out_pin2,
   input wire logic [7:0] o_compare_value_1,
   input wire logic [7:0] o_compare_value_2,
   input wire logic [7:0] o_counter,
   input wire logic       o_match_flag_1,
   input wire logic       o_match_flag_2,
   input wire logic       o_overflow_flag,
   input wire logic       o_timer_irq
);
   default clocking dclk @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);

   reset_clears_a: assert property (disable iff (1'h0) !i_rst_b |=>
      o_compare_value_1 == 8'h00 && o_compare_value_2 == 8'h00 &&
      !o_compare_out_pin1 && !o_compare_out_pin2 && !o_timer_irq)
      else $error("compare state not cleared by reset");
   cmp_write_a: assert property (
      i_cmp1_wr |=> o_compare_value_1 == $past(i_wdata))
      else $error("compare value 1 not written");
   cmp_hold_a: assert property (
      !i_cmp1_wr && !i_cmp2_wr |=> $stable(o_compare_value_1) &&
      $stable(o_compare_value_2)) else $error("compare value changed");
   oe_follow_a: assert property ($past(i_rst_b) |->
      o_compare_out_pin1_oe == $past(i_compare_pin1_enable))
      else $error("pin enable not followed");
   div2_match_a: assert property (i_prescale_select == 2'h0 &&
      $stable({i_pwm_select, i_single_pulse_select, i_prescale_select}) &&
      !i_pwm_select && !i_single_pulse_select && $changed(o_counter) &&
      o_counter == o_compare_value_1 |=> o_match_flag_1 &&
      (!$past(i_compare_pin1_enable) ||
      o_compare_out_pin1 == $past(i_level_bit_first)))
      else $error("match not taken at equal count");
   irq_masked_a: assert property (
      i_cpu_irq_mask && $past(i_cpu_irq_mask) |-> !o_timer_irq)
      else $error("interrupt while masked");
   irq_raise_a: assert property (
      (o_match_flag_1 && i_compare_irq_enable && !i_cpu_irq_mask) [*2]
      |-> o_timer_irq) else $error("interrupt missing");
   force_copy_a: assert property ((i_force_level_bit_1 &&
      i_compare_pin1_enable && i_level_bit_first && !i_pwm_select &&
      !i_single_pulse_select) [*3] |-> o_compare_out_pin1)
      else $error("forced level not on pin");
   pwm_no_flags_a: assert property (i_pwm_select &&
      $past(i_pwm_select) && $past(i_pwm_select, 2) |->
      !$rose(o_match_flag_1) && !$rose(o_match_flag_2))
      else $error("match flag set in pwm");
   pulse_no_flag_a: assert property (i_single_pulse_select &&
      $past(i_single_pulse_select) && $past(i_single_pulse_select, 2)
      |-> !$rose(o_match_flag_1)) else $error("flag 1 set in pulse");
   overflow_set_a: assert property (
      $past(o_counter) == 8'hFF && o_counter == 8'h00 |->
      ##[1:3] o_overflow_flag) else $error("overflow flag missing");
endmodule : tcp_compare_props

bind tcp_compare tcp_compare_props #(.DIV_SLOW(DIV_SLOW)) props (.*);

// ===== timer8_compare_pulse_pwm_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   fails++; $display("unexpected %s exp %h got %h", n, e, g); end end

module timer8_compare_pulse_pwm_test;
   localparam logic [13:0] DIV_SLOW = 14'h000A;
   logic       i_core_clk = 1'h0, i_rst_b = 1'h0;
   logic [7:0] i_wdata = 8'h00;
   logic [1:0] i_prescale_select = 2'h0;
   logic i_cmp1_wr = 1'h0, i_cmp2_wr = 1'h0, i_cmp1_rd = 1'h0;
   logic i_cmp2_rd = 1'h0, i_cap1_rd = 1'h0, i_cap2_rd = 1'h0;
   logic i_cnt_rd = 1'h0, i_cnt_wr = 1'h0, i_status_rd = 1'h0;
   logic i_capture_irq_enable = 1'h0, i_compare_irq_enable = 1'h0;
   logic i_overflow_irq_enable = 1'h0, i_cpu_irq_mask = 1'h0;
   logic i_force_level_bit_1 = 1'h0, i_force_level_bit_2 = 1'h0;
   logic i_level_bit_first = 1'h0, i_level_bit_second = 1'h0;
   logic i_capture1_edge_select = 1'h1, i_capture2_edge_select = 1'h1;
   logic i_compare_pin1_enable = 1'h0, i_compare_pin2_enable = 1'h0;
   logic i_single_pulse_select = 1'h0, i_pwm_select = 1'h0;
   logic i_capture_in_pin1, i_capture_in_pin2;
   logic o_compare_out_pin1, o_compare_out_pin1_oe, o_compare_out_pin2;
   logic o_compare_out_pin2_oe, o_match_flag_1, o_match_flag_2;
   logic o_capture_flag_1, o_capture_flag_2, o_overflow_flag, o_timer_irq;
   logic [7:0] o_compare_value_1, o_compare_value_2, o_capture_value_1;
   logic [7:0] o_capture_value_2, o_counter;
   int         fails = 0, check_count = 0;

   always #25 i_core_clk = !i_core_clk;

   tcp_compare #(.DIV_SLOW(DIV_SLOW)) DUT (.*);
   tcp_ext_model ext (.i_core_clk(i_core_clk), .o_cap1(i_capture_in_pin1),
                      .o_cap2(i_capture_in_pin2));

   // ----------------------------------------------------------------------
   // Expectations and bus helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] target(input logic [7:0] v,
                                         input logic [1:0] s);
      return (s == 2'h0) ? v : v + 8'h01;
   endfunction : target

   function automatic int divisor(input logic [1:0] s);
      return (s == 2'h3) ? int'(DIV_SLOW) : 2 << s;
   endfunction : divisor

   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : cyc

   task wr(input logic [7:0] v1, input logic [7:0] v2);
      i_wdata <= v1;
      i_cmp1_wr <= 1'h1;
      cyc(1);
      i_cmp1_wr <= 1'h0;
      i_wdata <= v2;
      i_cmp2_wr <= 1'h1;
      cyc(1);
      i_cmp2_wr <= 1'h0;
      cyc(1);
   endtask : wr

   task clr;
      i_status_rd <= 1'h1;
      cyc(1);
      i_status_rd <= 1'h0;
      {i_cmp1_rd, i_cmp2_rd, i_cap1_rd, i_cap2_rd, i_cnt_rd} <= 5'h1F;
      cyc(1);
      {i_cmp1_rd, i_cmp2_rd, i_cap1_rd, i_cap2_rd, i_cnt_rd} <= 5'h00;
      cyc(2);
   endtask : clr

   task wait_cnt(input logic [7:0] v, input int lim);
      int n;
      n = 0;
      while (o_counter !== v && n < lim) begin
         cyc(1);
         n++;
      end
      `CHK("count reached", 1'h1, n < lim)
   endtask : wait_cnt

   task span(output int n);
      logic [7:0] v;
      v = o_counter;
      while (o_counter === v)
         cyc(1);
      v = o_counter;
      n = 0;
      while (o_counter === v) begin
         cyc(1);
         n++;
      end
   endtask : span

   task conclude;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   initial begin
      repeat (80000) @(posedge i_core_clk);
      $display("unexpected timeout");
      fails++;
      conclude;
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   initial begin
      int n;
      logic [7:0] v, p;
      logic lvl;
      void'($urandom(7927));
      cyc(5);
      `CHK("reset value", 8'h00, o_compare_value_1)
      `CHK("reset pin", 1'h0, o_compare_out_pin1)
      i_rst_b <= 1'h1;
      i_compare_pin1_enable <= 1'h1;
      i_level_bit_first <= 1'h1;
      i_force_level_bit_1 <= 1'h1;
      cyc(4);
      `CHK("forced pin", 1'h1, o_compare_out_pin1)
      `CHK("force flag", 1'h0, o_match_flag_1)
      wait_cnt(8'h02, 40);
      `CHK("overflow", 1'h1, o_overflow_flag)
      i_force_level_bit_1 <= 1'h0;
      for (int k = 0; k < 4; k++) begin
         v = 8'($urandom);
         p = 8'($urandom);
         wr(v, p);
         `CHK("compare 1", v, o_compare_value_1)
      end
      cyc(600);
      `CHK("compare 2", p, o_compare_value_2)
      i_rst_b <= 1'h0;
      cyc(2);
      i_rst_b <= 1'h1;
      cyc(1);
      `CHK("rerun reset", 16'h0000, {o_compare_value_1, o_compare_value_2})
      `CHK("rerun pin", 1'h0, o_compare_out_pin1)
      i_compare_irq_enable <= 1'h1;
      for (int s = 0; s < 4; s++) begin
         lvl = 1'($urandom);
         v = 8'h10 + 8'($urandom % 200);
         i_prescale_select <= 2'(s);
         i_compare_pin1_enable <= !s[0];
         i_level_bit_first <= lvl;
         i_cpu_irq_mask <= (s == 2);
         wr(v, v);
         span(n);
         `CHK("tick span", divisor(2'(s)), n)
         // Clear old flags half a turn away from the match.
         wait_cnt(v + 8'h80, 3000);
         clr;
         wait_cnt(v - 8'h02, 3000);
         wait_cnt(target(v, 2'(s)), 40);
         p = o_compare_out_pin1;
         `CHK("flag early", 1'h0, o_match_flag_1)
         cyc(1);
         `CHK("flag set", 1'h1, o_match_flag_1)
         `CHK("pin level", s[0] ? p : lvl, o_compare_out_pin1)
         cyc(1);
         `CHK("irq", s != 2, o_timer_irq)
         i_cmp1_rd <= 1'h1;
         cyc(1);
         i_cmp1_rd <= 1'h0;
         cyc(2);
         `CHK("early clear", 1'h1, o_match_flag_1)
      end
      clr;
      `CHK("cleared", 1'h0, o_match_flag_1)
      i_prescale_select <= 2'h0;
      i_cpu_irq_mask <= 1'h0;
      i_compare_pin2_enable <= 1'h1;
      i_compare_pin1_enable <= 1'h1;
      i_level_bit_first <= 1'h0;
      i_level_bit_second <= 1'h1;
      i_force_level_bit_2 <= 1'h1;
      i_single_pulse_select <= 1'h1;
      wr(8'h40, 8'h20);
      clr;
      wait_cnt(8'h08, 600);
      ext.edge_on(1'h0, 1'h1);
      cyc(6);
      `CHK("pulse capture", 8'hFD, o_capture_value_1)
      `CHK("pulse cap flag", 1'h1, o_capture_flag_1)
      `CHK("pulse start", 1'h1, o_compare_out_pin1)
      `CHK("pulse reload", 1'h1, o_counter >= 8'hFC)
      wait_cnt(8'h30, 200);
      `CHK("pulse held", 1'h1, o_compare_out_pin1)
      wait_cnt(8'h40, 40);
      cyc(2);
      `CHK("pulse end", 1'h0, o_compare_out_pin1)
      `CHK("pulse flag 1", 1'h0, o_match_flag_1)
      `CHK("pulse flag 2", 1'h1, o_match_flag_2)
      `CHK("pulse pin 2", 1'h0, o_compare_out_pin2)
      `CHK("pin 2 oe", 1'h1, o_compare_out_pin2_oe)
      ext.edge_on(1'h1, 1'h1);
      cyc(6);
      `CHK("capture 2", 1'h1, o_capture_flag_2)
      i_level_bit_first <= 1'h1;
      i_level_bit_second <= 1'h0;
      i_force_level_bit_1 <= 1'h1;
      i_capture_irq_enable <= 1'h1;
      wr(8'h10, 8'h30);
      i_pwm_select <= 1'h1;
      clr;
      wait_cnt(8'h30, 600);
      cyc(3);
      `CHK("pwm reload", 1'h1, o_counter >= 8'hFC)
      `CHK("pwm second", 1'h0, o_compare_out_pin1)
      `CHK("pwm cap flag", 1'h1, o_capture_flag_1)
      `CHK("pwm irq", 1'h1, o_timer_irq)
      wait_cnt(8'h12, 60);
      `CHK("pwm first", 1'h1, o_compare_out_pin1)
      wr(8'h10, 8'h20);
      wait_cnt(8'h25, 60);
      wait_cnt(8'h30, 60);
      wait_cnt(8'h20, 80);
      cyc(4);
      `CHK("pwm new period", 1'h1, o_counter >= 8'hFC)
      `CHK("pwm flags", 2'h0, {o_match_flag_1, o_match_flag_2})
      conclude;
   end
endmodule : timer8_compare_pulse_pwm_test
